//--- src/sync_code_pkg.sv
// Shared constants and carrier types for the sync-code decoder.
// Assumes one pixel clock domain and an active-low asynchronous reset.
package sync_code_pkg;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [11:0] ONES_12 = 12'hfff;
  localparam logic [11:0] ONES_10 = 12'h3ff;
  localparam logic [11:0] ZERO_WORD = 12'h000;
  localparam int unsigned TOP_BIT_10 = 9;
  localparam int unsigned TOP_BIT_12 = 11;
  localparam int unsigned BLANK_BIT_10 = 7;
  localparam int unsigned BLANK_BIT_12 = 9;
  localparam int unsigned END_BIT_10 = 6;
  localparam int unsigned END_BIT_12 = 8;
  localparam int unsigned PROT_LSB_10 = 2;
  localparam int unsigned PROT_LSB_12 = 4;
  localparam logic [3:0] PROT_00 = 4'h0;
  localparam logic [3:0] PROT_01 = 4'hd;
  localparam logic [3:0] PROT_10 = 4'hb;
  localparam logic [3:0] PROT_11 = 4'h6;
  localparam logic FV_RESET = 1'b0;
  localparam logic LV_RESET = 1'b0;

  typedef enum logic {
    ten_bit_pixel_format,
    twelve_bit_pixel_format
  } pixel_format_t;

  typedef struct packed {
    logic [WORD_W-1:0] pixel;
    logic frame_valid;
    logic line_valid;
  } pixel_beat_t;

  typedef struct packed {
    logic blanking;
    logic end_code;
    logic prot_ok;
  } code_flags_t;
endpackage

//--- src/pixel_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
module pixel_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  logic in_ready_q, in_ready_d;

  // Ready registered from the next pointer values
  always_comb begin
    in_ready = in_ready_q;
    out_valid = wr_q != rd_q;
    out_data = mem_q[rd_q[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    in_ready_d = (wr_d - rd_d) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      in_ready_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      in_ready_q <= in_ready_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- src/sensor_sync_code_decoder.sv
// Sync-code decoder: finds start/end codes in aligned pixel words and
// produces frame-valid, line-valid and data-valid with the pixel bus.
// Assumes words arrive aligned, one per core_clk when word_valid is high.
// How it works
// (R1) Words are 10 or 12 bits wide as pixel_format selects, and the code layout follows that width.
// (R2) The sensor brackets each line's pixels with a start code before and an end code after.
// (R3) A code is four words: all ones, all zeros, all zeros, then a flag word.
// (R4) The blanking flag is bit 7 (10-bit) or bit 9 (12-bit) of the flag word; one means blanking.
// (R5) The end flag is bit 6 (10-bit) or bit 8 (12-bit); one is an end code, zero a start code.
// (R6) The sensor paces lines and frames by the sync pulses it is given.
// (R7) Four protection bits follow the flag pair per the fixed table, low bits zero, top bit one.
// (R8) Frame-valid spans active frames; line-valid rises on start and falls on end of active lines.
// (R9) Data-valid is high only in cycles when the pixel bus holds a pixel.
module sensor_sync_code_decoder
  import sync_code_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pixel_format_t pixel_format,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic out_ready,
  output logic [WORD_W-1:0] pixel_out,
  output logic data_valid_out,
  output logic frame_valid_out,
  output logic line_valid_out,
  output logic code_error
);
  typedef enum logic [1:0] {
    seek_ones,
    seek_zero_a,
    seek_zero_b,
    seek_flags
  } code_state_t;

  code_state_t state_q, state_d;
  logic fv_q, fv_d, lv_q, lv_d, err_q, err_d;
  logic [WORD_W-1:0] word_m;
  logic is_ones, is_zero;
  code_flags_t flags;
  pixel_beat_t beat_in, beat_out;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [WORD_W-1:0] pend_q [3];
  logic [WORD_W-1:0] pend_d [3];
  logic [1:0] pend_n_q, pend_n_d;
  logic [WORD_W-1:0] pix_q, pix_d;
  logic dv_q, dv_d, fv_o_q, fv_o_d, lv_o_q, lv_o_d;

  // Protection nibble expected for a flag pair
  function automatic logic [3:0] prot_for(input logic blank, input logic fin);
    case ({blank, fin})
      2'b00: prot_for = PROT_00;
      2'b01: prot_for = PROT_01;
      2'b10: prot_for = PROT_10;
      default: prot_for = PROT_11;
    endcase
  endfunction

  // Extract flags and check the flag word layout
  function automatic code_flags_t decode_flags(input logic [WORD_W-1:0] w,
                                               input pixel_format_t fmt);
    code_flags_t f;
    f = '0;
    if (fmt == ten_bit_pixel_format) begin
      f.blanking = w[BLANK_BIT_10]; // see (R4)
      f.end_code = w[END_BIT_10]; // see (R5)
      f.prot_ok = w[TOP_BIT_10] && (w[1:0] == 2'b00) && // see (R7)
        (w[PROT_LSB_10 +: 4] == prot_for(f.blanking, f.end_code));
    end else begin
      f.blanking = w[BLANK_BIT_12]; // see (R4)
      f.end_code = w[END_BIT_12]; // see (R5)
      f.prot_ok = w[TOP_BIT_12] && (w[3:0] == 4'h0) && // see (R7)
        (w[PROT_LSB_12 +: 4] == prot_for(f.blanking, f.end_code));
    end
    decode_flags = f;
  endfunction

  always_comb begin
    word_m = (pixel_format == ten_bit_pixel_format) ? (word_in & ONES_10) : word_in; // see (R1)
    is_ones = (pixel_format == ten_bit_pixel_format) ? (word_m == ONES_10)
                                                     : (word_m == ONES_12); // see (R1)
    is_zero = word_m == ZERO_WORD;
    flags = decode_flags(word_m, pixel_format);
  end

  // Accept a word only when the FIFO can take any pixel it may release
  assign word_ready = fifo_in_ready;

  // Code search; candidate code words are held back from the pixel stream;
  // a break at the second word releases only the held ones word, a break at the third drops them all.
  always_comb begin
    state_d = state_q;
    fv_d = fv_q;
    lv_d = lv_q;
    err_d = 1'b0;
    pend_d = pend_q;
    pend_n_d = pend_n_q;
    fifo_in_valid = 1'b0;
    beat_in.pixel = word_m;
    beat_in.frame_valid = fv_q;
    beat_in.line_valid = lv_q;
    if (word_valid && word_ready) begin
      case (state_q) // see (R3)
        seek_ones: begin
          if (is_ones) begin
            state_d = seek_zero_a;
            pend_d[0] = word_m;
            pend_n_d = 2'd1;
          end else begin
            fifo_in_valid = lv_q; // see (R9)
          end
        end
        seek_zero_a: begin
          if (is_zero) begin
            state_d = seek_zero_b;
            pend_d[1] = word_m;
            pend_n_d = 2'd2;
          end else begin
            state_d = seek_ones;
            pend_n_d = 2'd0;
            beat_in.pixel = pend_q[0];
            fifo_in_valid = lv_q;
            err_d = 1'b1;
          end
        end
        seek_zero_b: begin
          if (is_zero) begin
            state_d = seek_flags;
            pend_n_d = 2'd3;
          end else begin
            state_d = seek_ones;
            pend_n_d = 2'd0;
            err_d = 1'b1;
          end
        end
        default: begin
          state_d = seek_ones;
          pend_n_d = 2'd0;
          if (flags.prot_ok) begin
            // Active start opens line and frame; blanking code closes frame
            if (flags.blanking) begin
              fv_d = 1'b0; // see (R8)
              lv_d = 1'b0; // see (R8)
            end else if (!flags.end_code) begin
              fv_d = 1'b1; // see (R8)
              lv_d = 1'b1; // see (R8)
            end else begin
              lv_d = 1'b0; // see (R8)
            end
          end else begin
            err_d = 1'b1;
          end
        end
      endcase
    end
  end

  pixel_fifo #(
    .WIDTH($bits(pixel_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(beat_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(beat_out),
    .out_valid(fifo_out_valid),
    .out_ready(out_ready)
  );

  // Registered output stage; pixel holds last value when idle
  always_comb begin
    pix_d = pix_q;
    dv_d = fifo_out_valid && out_ready; // see (R9)
    fv_o_d = fv_q;
    lv_o_d = lv_q;
    if (fifo_out_valid && out_ready) begin
      pix_d = beat_out.pixel;
      fv_o_d = beat_out.frame_valid;
      lv_o_d = beat_out.line_valid;
    end else if (fifo_out_valid) begin
      fv_o_d = fv_o_q;
      lv_o_d = lv_o_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= seek_ones;
      fv_q <= FV_RESET;
      lv_q <= LV_RESET;
      err_q <= 1'b0;
      pend_n_q <= 2'd0;
      pend_q[0] <= ZERO_WORD;
      pend_q[1] <= ZERO_WORD;
      pend_q[2] <= ZERO_WORD;
      pix_q <= ZERO_WORD;
      dv_q <= 1'b0;
      fv_o_q <= FV_RESET;
      lv_o_q <= LV_RESET;
    end else begin
      state_q <= state_d;
      fv_q <= fv_d;
      lv_q <= lv_d;
      err_q <= err_d;
      pend_n_q <= pend_n_d;
      pend_q <= pend_d;
      pix_q <= pix_d;
      dv_q <= dv_d;
      fv_o_q <= fv_o_d;
      lv_o_q <= lv_o_d;
    end
  end

  assign pixel_out = pix_q;
  assign data_valid_out = dv_q;
  assign frame_valid_out = fv_o_q;
  assign line_valid_out = lv_o_q;
  assign code_error = err_q;
endmodule

//--- tb/sync_decoder_checker.sv
// Port-level checks of the sync-code decoder.
// Assumes it is bound onto every decoder instance.
module sync_decoder_checker
  import sync_code_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pixel_format_t pixel_format,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic out_ready,
  input wire logic [WORD_W-1:0] pixel_out,
  input wire logic data_valid_out,
  input wire logic frame_valid_out,
  input wire logic line_valid_out,
  input wire logic code_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] m;
  assign m = pixel_format == twelve_bit_pixel_format ? ONES_12 : ONES_10;
  function automatic logic [11:0] fw(logic tw, logic v, logic h);
    logic [3:0] p;
    p = {v ^ h, h, v, v ^ h};
    return tw ? {2'b10, v, h, p, 4'h0} : {4'b0010, v, h, p, 2'b00};
  endfunction
  sequence tk(logic [11:0] x);
    word_valid && word_ready && (word_in & m) == x;
  endsequence
  sequence code(logic v, logic h, logic [11:0] e);
    tk(m) ##1 tk(ZERO_WORD) ##1 tk(ZERO_WORD) ##1 tk(fw(pixel_format, v, h) ^ e);
  endsequence
  a_dv_in_line: assert property (data_valid_out |-> line_valid_out && frame_valid_out)
    else $error("pixel outside an active line");
  a_lv_in_frame: assert property (line_valid_out |-> frame_valid_out)
    else $error("line valid outside frame");
  a_pix_hold: assert property (!data_valid_out |-> $stable(pixel_out))
    else $error("pixel bus moved without data valid");
  a_dv_after_ready: assert property (data_valid_out |-> $past(out_ready))
    else $error("pixel delivered without consumer ready");
  a_start_line: assert property (code(0, 0, 0) |-> ##[1:100] line_valid_out)
    else $error("start code did not raise line valid");
  a_end_line: assert property (code(0, 1, 0) |-> ##[1:100] !line_valid_out)
    else $error("end code did not drop line valid");
  a_blank_frame: assert property (code(1, 0, 0) |-> ##[1:100] !frame_valid_out)
    else $error("blanking code did not end frame");
  a_bad_prot: assert property (code(0, 0, 12'h010) |-> ##[1:4] code_error)
    else $error("bad protection bits not flagged");
  a_good_quiet: assert property (code(0, 0, 0) |-> ##1 !code_error [*2])
    else $error("good code flagged");
endmodule
bind sensor_sync_code_decoder sync_decoder_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .pixel_format(pixel_format), .word_in(word_in), .word_valid(word_valid),
  .word_ready(word_ready), .out_ready(out_ready), .pixel_out(pixel_out),
  .data_valid_out(data_valid_out),
  .frame_valid_out(frame_valid_out), .line_valid_out(line_valid_out), .code_error(code_error));

//--- tb/sensor_lane_model.sv
// Sensor lane model: offers aligned words and whole sync codes.
// Assumes the caller paces lines and frames.
module sensor_lane_model
  import sync_code_pkg::*;
(
  input wire logic core_clk,
  input wire pixel_format_t pixel_format,
  input wire logic word_ready,
  output logic [WORD_W-1:0] word_in,
  output logic word_valid = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int stuck = 0;
  logic [11:0] dat = 12'h000;
  logic [11:0] noise = 12'h5a5;
  // Released lane shows a changing pattern
  assign word_in = word_valid ? dat : noise;
  always @(posedge core_clk) noise <= ~noise;
  task automatic put(logic [11:0] w);
    int n;
    n = 0;
    dat <= w;
    word_valid <= 1'b1;
    @(posedge core_clk);
    while (!word_ready && n < 300) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 300) stuck++;
  endtask
  task automatic idle();
    word_valid <= 1'b0;
  endtask
  task automatic code(logic v, logic h, logic bad);
    logic tw;
    logic [3:0] p;
    tw = pixel_format == twelve_bit_pixel_format;
    p = {v ^ h, h, v, v ^ h};
    put(tw ? ONES_12 : ONES_10);
    put(ZERO_WORD);
    put(ZERO_WORD);
    put((tw ? {2'b10, v, h, p, 4'h0} : {4'b0010, v, h, p, 2'b00}) ^ {7'h0, bad, 4'h0});
  endtask
endmodule

//--- tb/tb_top.sv
// Top bench for the sync-code decoder with a sensor lane model.
// Assumes the checker binds itself onto the decoder.
module tb_top
  import sync_code_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, out_ready = 1'b0, stall = 1'b0;
  logic word_valid, word_ready, data_valid_out, frame_valid_out, line_valid_out, code_error;
  pixel_format_t pixel_format = ten_bit_pixel_format;
  logic [WORD_W-1:0] word_in, pixel_out;
  logic [11:0] exp_q[$];
  int n_fail = 0, compares = 0, errs = 0, seed = 32'h0dcbb055;
  sensor_sync_code_decoder i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .pixel_format(pixel_format), .word_in(word_in), .word_valid(word_valid),
    .word_ready(word_ready), .out_ready(out_ready), .pixel_out(pixel_out),
    .data_valid_out(data_valid_out), .frame_valid_out(frame_valid_out),
    .line_valid_out(line_valid_out), .code_error(code_error));
  sensor_lane_model i_sensor (.core_clk(core_clk), .pixel_format(pixel_format),
    .word_ready(word_ready), .word_in(word_in), .word_valid(word_valid));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) out_ready <= !stall && ($random(seed) & 1);
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rst_n && code_error === 1'b1) errs++;
    if (rst_n && data_valid_out === 1'b1) begin
      chk("pixel_out", exp_q.size() ? exp_q.pop_front() : 12'hxxx, pixel_out);
      chk("line_valid_out", 1, line_valid_out);
    end
  end
  task automatic line(int n, logic v, logic brk);
    logic [11:0] w;
    logic [11:0] ones;
    ones = pixel_format == twelve_bit_pixel_format ? ONES_12 : ONES_10;
    i_sensor.code(v, 1'b0, 1'b0);
    repeat (n) begin
      w = 12'($random(seed)) & ones;
      if (w == ONES_10 || w == ONES_12) w = 12'h001;
      if (!v) exp_q.push_back(w);
      i_sensor.put(w);
    end
    // Broken codes: a bad second word releases the ones word, a bad third drops all
    if (brk) begin
      exp_q.push_back(ones);
      i_sensor.put(ones);
      i_sensor.put(12'h001);
      i_sensor.put(ones);
      i_sensor.put(ZERO_WORD);
      i_sensor.put(12'h005);
    end
    i_sensor.code(v, 1'b1, 1'b0);
    i_sensor.idle();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk);
    if (exp_q.size() > 0) begin
      n_fail++;
      give_verdict();
    end else begin
      repeat (4) @(posedge core_clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    chk("word_ready", 1, word_ready);
    chk("frame_valid_out", 0, frame_valid_out);
    rst_n <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      pixel_format <= pixel_format_t'(f);
      @(posedge core_clk);
      // Consumer stalls so the buffer fills and refuses
      fork
        begin
          stall <= 1'b1;
          repeat (40) @(posedge core_clk);
          stall <= 1'b0;
        end
      join_none
      line(20, 1'b0, 1'b1);
      line(1, 1'b0, 1'b0);
      i_sensor.code(1'b0, 1'b0, 1'b1);
      i_sensor.idle();
      repeat (6) @(posedge core_clk);
      line(3, 1'b1, 1'b0);
      chk("frame_valid_out", 0, frame_valid_out);
    end
    chk("code_error count", 6, errs);
    chk("model stalls", 0, i_sensor.stuck);
    give_verdict();
  end
endmodule
